// ### pin_strap_config_loader_test.sv
// pin_strap_config_loader_test: strap, load, host and mute checks
// assumes: pscl_top with 8 channels, page store model on the read port
`timescale 1ns/10ps
module pin_strap_config_loader_test;
  import pscl_pkg::*;
  // stimulus
  logic       clk_in = 0, sys_rst_in = 1, pll_tick_in = 1;
  logic       config_source_select_pin_in = 1, power_down_pin_n_in = 1;
  logic [5:0] strap_bin_in = 6'h00;
  logic [1:0] strap1_lvl_in = 0, strap2_lvl_in = 0, strap3_lvl_in = 0;
  logic [2:0] freq_offset_select_a_in = 3'h5;
  logic       host_wr_en_in = 0, host_rd_en_in = 0;
  logic [6:0] host_addr_in = 0;
  logic [7:0] host_wr_data_in = 0, source_ok_in = 8'hFF;
  logic [1:0] status_ind_in = 0;
  // observed
  logic       page_rd_en_out, host_rd_valid_out, host_if_enable_out;
  logic       config_mode_hard_out, config_invalid_out, freq_offset_select_a_enable_out;
  logic [1:0] page_rd_src_out, i2c_addr_lsb_out, stat_pin_out, stat_slew_out;
  logic [5:0] page_rd_page_out;
  logic [6:0] page_rd_addr_out;
  logic [2:0] freq_offset_select_a_offset_out;
  logic [7:0] page_rd_data_in, host_rd_data_out, config_page_id_out;
  logic [7:0] chan_pos_out, chan_neg_out, chan_oe_out, d;
  logic       dflt;
  logic [5:0] ep;
  int         err_count = 0, checked = 0;

  pscl_top DUT (.*);
  pscl_page_model MODEL (.clk_in(clk_in), .en_in(page_rd_en_out),
    .page_in(page_rd_page_out), .addr_in(page_rd_addr_out),
    .data_out(page_rd_data_in));

  initial forever #20 clk_in = ~clk_in;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // host read: strobe one cycle, data and valid one cycle later
  task rd(input logic [6:0] a);
    @(negedge clk_in);
    host_rd_en_in = 1;
    host_addr_in = a;
    @(negedge clk_in);
    host_rd_en_in = 0;
    d = host_rd_data_out;
  endtask

  task wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk_in);
    host_wr_en_in = 1;
    host_addr_in = a;
    host_wr_data_in = v;
    @(negedge clk_in);
    host_wr_en_in = 0;
  endtask

  // set straps, cycle the power-down pin, wait for the host interface
  task boot(input logic h, input logic [5:0] b, input logic [1:0] s1,
            input logic [1:0] s2, input logic [1:0] s3);
    @(negedge clk_in);
    config_source_select_pin_in = h;
    strap_bin_in = b;
    strap1_lvl_in = s1;
    strap2_lvl_in = s2;
    strap3_lvl_in = s3;
    power_down_pin_n_in = 0;
    repeat (5) @(negedge clk_in);
    chk(chan_oe_out | {7'h0, host_if_enable_out}, 8'h00);
    power_down_pin_n_in = 1;
    for (int i = 0; i < 400 && host_if_enable_out !== 1'b1; i++)
      @(negedge clk_in);
    chk({7'h0, host_if_enable_out}, 8'h01);
  endtask

  initial begin
    repeat (5) @(negedge clk_in);
    sys_rst_in = 0;
    boot(1, 6'h2A, 2'h2, 2'h2, 2'h2);
    chk({2'h0, page_rd_page_out}, 8'h2A);
    chk({6'h0, page_rd_src_out}, 8'h00);
    chk({6'h0, i2c_addr_lsb_out}, 8'h00);
    chk(config_page_id_out, 8'h2A);
    chk({7'h0, config_mode_hard_out}, 8'h01);
    rd(7'h09);
    chk(d, 8'h09 ^ 8'h2A);
    chk({7'h0, host_rd_valid_out}, 8'h01);
    strap_bin_in = 6'h15;
    wr(7'h10, 8'h5C);
    rd(7'h10);
    chk(d, 8'h5C);
    rd(7'h7C);
    chk(d, 8'h00);
    chk({2'h0, page_rd_page_out}, 8'h2A);
    // soft mode: every page-select combination
    for (int c = 0; c < 9; c++) begin
      boot(0, 6'h11, 2'(c % 3), 2'(c % 3), 2'(c / 3));
      dflt = (c == 4 || c > 6);
      ep = 6'(c < 4 ? c : c - 1);
      chk({6'h0, i2c_addr_lsb_out}, c % 3 == 2 ? 8'h03 : 8'(c % 3));
      chk({6'h0, page_rd_src_out}, dflt ? 8'h02 : 8'h01);
      chk({7'h0, config_invalid_out}, 8'(c > 6));
      chk({7'h0, config_mode_hard_out}, 8'h00);
      if (!dflt)
        chk({2'h0, page_rd_page_out}, {2'h0, ep});
      rd(REG_FMT_BASE);
      chk(d, dflt ? FMT_RST : {1'b0, REG_FMT_BASE} ^ {2'h0, ep});
    end
    chk({7'h0, freq_offset_select_a_enable_out}, 8'h01);
    chk({5'h0, freq_offset_select_a_offset_out}, 8'h05);
    // active-low sync holds every divider, so diff legs stay put
    strap_bin_in = 6'h10;
    repeat (6) @(negedge clk_in);
    chk(chan_pos_out, 8'h00);
    chk(chan_neg_out, 8'hFF);
    repeat (4) @(negedge clk_in);
    chk(chan_pos_out, 8'h00);
    strap_bin_in = 6'h11;
    // status pin 0 as indicator with slew bit, pin 1 as clock
    status_ind_in = 2'h2;
    wr(REG_STAT_MODE_BASE, 8'h02);
    repeat (2) @(negedge clk_in);
    chk({4'h0, stat_slew_out, stat_pin_out}, 8'h06);
    wr(REG_STAT_MODE_BASE + 7'h01, 8'h01);
    repeat (3) @(negedge clk_in);
    d = {7'h0, stat_pin_out[1]};
    @(negedge clk_in);
    chk({7'h0, stat_pin_out[1]} ^ d, 8'h01);
    // lost source mutes with the default diff setting
    source_ok_in = 8'h00;
    repeat (4) @(negedge clk_in);
    chk(chan_pos_out, 8'hFF);
    chk(chan_neg_out, 8'h00);
    wr(REG_FMT_BASE, 8'h1F);
    repeat (3) @(negedge clk_in);
    chk({6'h0, chan_pos_out[0], chan_neg_out[0]}, 8'h00);
    wr(REG_FMT_BASE, 8'h18);
    repeat (3) @(negedge clk_in);
    chk({7'h0, chan_oe_out[0]}, 8'h00);
    finish_test;
  end

  // hang guard, well past ten boots and the checks
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    finish_test;
  end
endmodule // pin_strap_config_loader_test

// ### pscl_chan_if.sv
// pscl_chan_if: configuration and pin levels of one output channel
// assumes: driven by the loader top, consumed by pscl_out_chan
`timescale 1ns/10ps
interface pscl_chan_if import pscl_pkg::*; ();
  logic [7:0] div;
  pscl_fmt_e  fmt;
  logic       mute_en;
  logic [1:0] mute_lvl;
  logic       sync;
  logic       run;
  logic       src_ok;
  logic       tick;
  logic       pos;
  logic       neg;
  logic       oe;
  modport ctrl (output div, fmt, mute_en, mute_lvl, sync, run, src_ok, tick,
                input pos, neg, oe);
  modport chan (input div, fmt, mute_en, mute_lvl, sync, run, src_ok, tick,
                output pos, neg, oe);
endinterface // pscl_chan_if

// ### pscl_out_chan.sv
// pscl_out_chan: one output channel, divider, format and auto mute
// assumes: tick is a same-clock pulse per half period of the post divider
`timescale 1ns/10ps
module pscl_out_chan import pscl_pkg::*; (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // channel
  pscl_chan_if.chan ch
);
  logic [7:0] cnt_q;
  logic       ph_q;
  logic       pos_q, neg_q, oe_q;

  // mute decode and leg levels
  wire muted   = !ch.src_ok && ch.mute_en;
  wire is_diff = (ch.fmt == FMT_DIFF) || (ch.fmt == FMT_HCSL);
  wire rail    = (ch.mute_lvl == MUTE_LVL_RAIL);
  wire wrap    = ch.tick && (cnt_q == ch.div);
  wire pos_d   = muted ? (rail && is_diff) : ph_q;
  wire neg_d   = muted ? 1'b0 : (is_diff ? !ph_q : ph_q);
  wire live    = ch.run && (ch.fmt != FMT_OFF);

  // divider: phase toggles every div+1 ticks, cleared by sync
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || ch.sync || !ch.run) begin
      cnt_q <= 8'h00;
      ph_q  <= 1'b0;
    end else if (ch.tick) begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      ph_q  <= wrap ? !ph_q : ph_q;
    end
  end

  // registered pin levels, off while not running or disabled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !live) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
      oe_q  <= 1'b1;
    end
  end

  assign ch.pos = pos_q;
  assign ch.neg = neg_q;
  assign ch.oe  = oe_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // differential mute at level 3: positive to rail, negative to ground
  a_mute_diff_legs: assert property (
    (live && is_diff && muted && rail) |=> (pos_q && !neg_q && oe_q))
    else $error("muted differential legs wrong");

  // single-ended mute: forced low
  a_mute_cmos_low: assert property (
    (live && ch.fmt == FMT_CMOS && muted) |=> (!pos_q && !neg_q))
    else $error("muted single-ended output not low");

  // divider wraps after div+1 ticks
  a_div_wrap_count: assert property (
    (ch.run && !ch.sync && wrap) |=> (cnt_q == 8'h00 && ph_q != $past(ph_q)))
    else $error("divider did not wrap");
endmodule // pscl_out_chan

// ### pscl_page_model.sv
// pscl_page_model: page store behind the loader read port
// assumes: address taken on clk_in, data one cycle later
`timescale 1ns/10ps
module pscl_page_model (
  // read port
  input  wire logic       clk_in,
  input  wire logic       en_in,
  input  wire logic [5:0] page_in,
  input  wire logic [6:0] addr_in,
  output logic      [7:0] data_out
);
  initial data_out = 8'h5A;
  // answer late by one cycle; idle port shows a changing pattern
  // read only, never programmed, so restarts cannot corrupt it
  always @(posedge clk_in) begin
    if (en_in)
      data_out <= {1'b0, addr_in} ^ {2'b0, page_in};
    else
      data_out <= ~data_out;
  end
endmodule // pscl_page_model

// ### pscl_pkg.sv
// pscl_pkg: constants, field layout and types of the strap configuration loader
// assumes: one 25 MHz clock; every user includes it with import pscl_pkg::*
package pscl_pkg;

  // register file geometry
  localparam int        NUM_REGS = 124;
  localparam int        REG_AW   = 7;
  localparam logic [6:0] LAST_REG = 7'h7B;

  // timing: clock period and the derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STRAP_SETTLE_NS = 200;
  localparam int SYNC_PULSE_NS   = 160;
  localparam int SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC =
    (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register offsets
  localparam logic [6:0] REG_PAGE_ID       = 7'h00;
  localparam logic [6:0] REG_DIV_BASE      = 7'h08;
  localparam logic [6:0] REG_FMT_BASE      = 7'h10;
  localparam logic [6:0] REG_STAT_MODE_BASE = 7'h18;
  localparam logic [6:0] REG_STAT_DIV_BASE = 7'h1A;

  // field positions
  localparam int FMT_LSB      = 0;
  localparam int MUTE_EN_BIT  = 2;
  localparam int MUTE_LVL_LSB = 3;
  localparam int STAT_CLK_BIT = 0;
  localparam int STAT_SLEW_BIT = 1;

  // register default values
  localparam logic [7:0] FMT_RST       = 8'h1D; // diff, mute on, level 3
  localparam logic [7:0] DIV_RST       = 8'h03; // divide by 4
  localparam logic [7:0] STAT_MODE_RST = 8'h00;
  localparam logic [7:0] OTHER_RST     = 8'h00;

  // mute level code that drives the documented rail/ground pattern
  localparam logic [1:0] MUTE_LVL_RAIL = 2'h3;

  // three-level pin codes from the pin comparator
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_VDD = 2'h2;

  // slave address low bits
  localparam logic [1:0] ADDR_LSB_HARD = 2'h0;
  localparam logic [1:0] ADDR_LSB_GND  = 2'h0;
  localparam logic [1:0] ADDR_LSB_MID  = 2'h1;
  localparam logic [1:0] ADDR_LSB_VDD  = 2'h3;

  // page-select combination index (3 * upper pin + lower pin)
  localparam logic [3:0] COMBO_DEFAULT  = 4'h4;
  localparam logic [3:0] COMBO_FIRST_BAD = 4'h7;

  typedef enum logic [1:0] {FMT_OFF, FMT_DIFF, FMT_HCSL, FMT_CMOS} pscl_fmt_e;
  typedef enum logic [1:0] {SRC_ROM, SRC_EEPROM, SRC_DEFAULT} pscl_src_e;

  // combination index of two three-level codes
  function automatic logic [3:0] pscl_combo(input logic [1:0] hi,
                                            input logic [1:0] lo);
    pscl_combo = 4'(hi) * 4'h3 + 4'(lo);
  endfunction

  // hardware default of one register
  function automatic logic [7:0] pscl_reg_default(input logic [6:0] a);
    if (a >= REG_DIV_BASE && a < REG_FMT_BASE)
      pscl_reg_default = DIV_RST;
    else if (a >= REG_FMT_BASE && a < REG_STAT_MODE_BASE)
      pscl_reg_default = FMT_RST;
    else if (a >= REG_STAT_MODE_BASE && a < REG_STAT_DIV_BASE)
      pscl_reg_default = STAT_MODE_RST;
    else
      pscl_reg_default = OTHER_RST;
  endfunction

endpackage

// ### pscl_sync.sv
// pscl_sync: two-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous pins, output is read by clk_in logic
`timescale 1ns/10ps
module pscl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // pin levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first flop feeds only the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // pscl_sync

// ### pscl_top.sv
// pscl_top: start-up configuration loader of a single-PLL clock generator
// assumes: strap pins asynchronous; page data, ticks and source-valid
// flags come from logic on clk_in; page data arrives one cycle after address
`timescale 1ns/10ps

// Function
// - mode high: six straps pick ROM page
// - hard mode: host interface on, address bits 00
// - hard mode: auto sync dividers at start
// - soft mode: two three-level pins pick page
// - both page pins floating: load hardware defaults
// - soft mode: strap 0 is active-low sync
// - soft mode: strap 1 sets address low bits
// - soft mode: margining enable and offset select
// - soft mode: straps latched at power-on reset
// - outputs disabled during reset and initialisation
// - host may rewrite any register once enabled
// - invalid source mutes per channel mute settings
// - muted differential: positive rail, negative ground; only at mute level 3, other levels drive both legs low
// - muted single-ended output forced low
// - eight-bit output divider, ratios 1 to 256
// - per channel output format or disabled
// - status pin is clock or indicator
// - each page holds readable eight-bit identifier
// - 124 eight-bit registers numbered from zero
module pscl_top import pscl_pkg::*; #(
  parameter int NUM_CH   = 8,
  parameter int NUM_STAT = 2
) (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  // strap and control pins
  input  wire logic                config_source_select_pin_in,
  input  wire logic                power_down_pin_n_in,
  input  wire logic [5:0]          strap_bin_in,
  input  wire logic [1:0]          strap1_lvl_in,
  input  wire logic [1:0]          strap2_lvl_in,
  input  wire logic [1:0]          strap3_lvl_in,
  input  wire logic [2:0]          freq_offset_select_a_in,
  // page store read port
  output logic                     page_rd_en_out,
  output logic [1:0]               page_rd_src_out,
  output logic [5:0]               page_rd_page_out,
  output logic [6:0]               page_rd_addr_out,
  input  wire logic [7:0]          page_rd_data_in,
  // host register access
  input  wire logic                host_wr_en_in,
  input  wire logic                host_rd_en_in,
  input  wire logic [6:0]          host_addr_in,
  input  wire logic [7:0]          host_wr_data_in,
  output logic [7:0]               host_rd_data_out,
  output logic                     host_rd_valid_out,
  output logic                     host_if_enable_out,
  output logic [1:0]               i2c_addr_lsb_out,
  // configuration status
  output logic                     config_mode_hard_out,
  output logic                     config_invalid_out,
  output logic [7:0]               config_page_id_out,
  output logic                     freq_offset_select_a_enable_out,
  output logic [2:0]               freq_offset_select_a_offset_out,
  // clock sources
  input  wire logic                pll_tick_in,
  input  wire logic [NUM_CH-1:0]   source_ok_in,
  input  wire logic [NUM_STAT-1:0] status_ind_in,
  // output channels
  output logic [NUM_CH-1:0]        chan_pos_out,
  output logic [NUM_CH-1:0]        chan_neg_out,
  output logic [NUM_CH-1:0]        chan_oe_out,
  // status pins
  output logic [NUM_STAT-1:0]      stat_pin_out,
  output logic [NUM_STAT-1:0]      stat_slew_out
);

  typedef enum logic [2:0] {
    ST_RESET, ST_SETTLE, ST_LATCH, ST_LOAD, ST_SYNC, ST_RUN
  } pscl_state_e;

  localparam int SYNC_W = 17;

  // synchronised pins
  logic [SYNC_W-1:0] pins_s;
  pscl_sync #(.W(SYNC_W)) u_pin_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     ({config_source_select_pin_in, power_down_pin_n_in,
                  strap_bin_in, strap1_lvl_in, strap2_lvl_in,
                  strap3_lvl_in, freq_offset_select_a_in}),
    .sync_out   (pins_s)
  );

  wire       cfg_hard_s = pins_s[16];
  wire       pdn_n_s    = pins_s[15];
  wire [5:0] bin_s      = pins_s[14:9];
  wire [1:0] lvl1_s     = pins_s[8:7];
  wire [1:0] lvl2_s     = pins_s[6:5];
  wire [1:0] lvl3_s     = pins_s[4:3];
  wire [2:0] off_s      = pins_s[2:0];
  wire       sync_n_s   = bin_s[0];

  // state, timers and latched straps
  pscl_state_e st_q, st_d;
  logic [3:0]  tmr_q;
  logic        mode_hard_q;
  logic [5:0]  rom_page_q;
  logic [5:0]  page_q;
  pscl_src_e   src_q;
  logic        invalid_q;
  logic [1:0]  i2c_lsb_q;
  logic        run_q;

  // load pipeline and register file
  logic [6:0]  ld_addr_q;
  logic        ld_en_q;
  logic [6:0]  cap_addr_q;
  logic        cap_en_q;
  logic [7:0]  regs_q [NUM_REGS];

  // host read and live strap outputs
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic        freq_offset_select_a_en_q;
  logic [2:0]  freq_offset_select_a_off_q;

  // page-select decode of the two three-level pins
  wire [3:0] combo_w    = pscl_combo(lvl3_s, lvl2_s);
  wire       combo_def  = (combo_w == COMBO_DEFAULT);
  wire       combo_bad  = (combo_w >= COMBO_FIRST_BAD);
  wire [5:0] combo_page = (combo_w < COMBO_DEFAULT) ? 6'(combo_w)
                                                    : 6'(combo_w - 4'h1);
  wire [1:0] lsb_soft_w = (lvl1_s == LVL_VDD) ? ADDR_LSB_VDD :
                          (lvl1_s == LVL_MID) ? ADDR_LSB_MID :
                                                ADDR_LSB_GND;

  // load and sequence decode
  wire load_done = cap_en_q && (cap_addr_q == LAST_REG);
  wire settled   = (tmr_q == 4'(SETTLE_CYC - 1));
  wire synced    = (tmr_q == 4'(SYNC_CYC - 1));
  wire [7:0] cap_data_w = (src_q == SRC_DEFAULT) ? pscl_reg_default(cap_addr_q)
                                                 : page_rd_data_in;
  wire host_ok   = run_q && (host_addr_in <= LAST_REG);

  // next-state decode; power-down pin restarts everything
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RESET:  st_d = ST_SETTLE;
      ST_SETTLE: st_d = settled ? ST_LATCH : ST_SETTLE;
      ST_LATCH:  st_d = ST_LOAD;
      ST_LOAD:   st_d = load_done ? (mode_hard_q ? ST_SYNC : ST_RUN)
                                  : ST_LOAD;
      ST_SYNC:   st_d = synced ? ST_RUN : ST_SYNC;
      ST_RUN:    st_d = ST_RUN;
    endcase
    if (!pdn_n_s)
      st_d = ST_RESET;
  end

  // state and phase timer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q  <= ST_RESET;
      tmr_q <= 4'h0;
      run_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      tmr_q <= (st_d != st_q) ? 4'h0 : tmr_q + 4'h1;
      run_q <= (st_d == ST_RUN);
    end
  end

  // straps sampled once per restart, held afterwards
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_hard_q <= 1'b0;
      rom_page_q  <= 6'h00;
      page_q      <= 6'h00;
      src_q       <= SRC_DEFAULT;
      invalid_q   <= 1'b0;
      i2c_lsb_q   <= ADDR_LSB_HARD;
    end else if (st_q == ST_LATCH) begin
      mode_hard_q <= cfg_hard_s;
      rom_page_q  <= bin_s;
      page_q      <= cfg_hard_s ? bin_s : combo_page;
      src_q       <= cfg_hard_s ? SRC_ROM :
                     (combo_def || combo_bad) ? SRC_DEFAULT : SRC_EEPROM;
      invalid_q   <= !cfg_hard_s && combo_bad;
      i2c_lsb_q   <= cfg_hard_s ? ADDR_LSB_HARD : lsb_soft_w;
    end
  end

  // page read address walk and capture pipeline
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || st_q != ST_LOAD) begin
      ld_addr_q  <= 7'h00;
      ld_en_q    <= (st_d == ST_LOAD) && !sys_rst_in;
      cap_addr_q <= 7'h00;
      cap_en_q   <= 1'b0;
    end else begin
      ld_en_q    <= ld_en_q && (ld_addr_q != LAST_REG);
      ld_addr_q  <= ld_en_q ? ld_addr_q + 7'h01 : ld_addr_q;
      cap_en_q   <= ld_en_q;
      cap_addr_q <= ld_addr_q;
    end
  end

  // register file: page load first, then host writes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= 8'h00;
    end else if (cap_en_q) begin
      regs_q[cap_addr_q] <= cap_data_w;
    end else if (host_wr_en_in && host_ok) begin
      regs_q[host_addr_in] <= host_wr_data_in;
    end
  end

  // host reads and live strap functions
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_q    <= 8'h00;
      rd_valid_q   <= 1'b0;
      freq_offset_select_a_en_q  <= 1'b0;
      freq_offset_select_a_off_q <= 3'h0;
    end else begin
      rd_valid_q   <= host_rd_en_in && run_q;
      rd_data_q    <= (host_rd_en_in && host_ok) ? regs_q[host_addr_in]
                                                 : 8'h00;
      freq_offset_select_a_en_q  <= run_q && !mode_hard_q && bin_s[4];
      freq_offset_select_a_off_q <= mode_hard_q ? 3'h0 : off_s;
    end
  end

  // output channels
  wire sync_w = mode_hard_q ? (st_q == ST_SYNC) : !sync_n_s;

  pscl_chan_if chif [NUM_CH] ();
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    wire [7:0] fmt_r = regs_q[REG_FMT_BASE + 7'(g)];
    assign chif[g].div      = regs_q[REG_DIV_BASE + 7'(g)];
    assign chif[g].fmt      = pscl_fmt_e'(fmt_r[FMT_LSB +: 2]);
    assign chif[g].mute_en  = fmt_r[MUTE_EN_BIT];
    assign chif[g].mute_lvl = fmt_r[MUTE_LVL_LSB +: 2];
    assign chif[g].sync     = sync_w;
    assign chif[g].run      = run_q;
    assign chif[g].src_ok   = source_ok_in[g];
    assign chif[g].tick     = pll_tick_in;
    assign chan_pos_out[g]  = chif[g].pos;
    assign chan_neg_out[g]  = chif[g].neg;
    assign chan_oe_out[g]   = chif[g].oe;
    pscl_out_chan u_chan (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ch         (chif[g])
    );
  end

  // status pins: divided clock or indicator
  pscl_chan_if sif [NUM_STAT] ();
  logic [NUM_STAT-1:0] stat_q, slew_q;
  for (genvar s = 0; s < NUM_STAT; s++) begin : g_stat
    wire [7:0] mode_r = regs_q[REG_STAT_MODE_BASE + 7'(s)];
    wire       is_clk = mode_r[STAT_CLK_BIT];
    assign sif[s].div      = regs_q[REG_STAT_DIV_BASE + 7'(s)];
    assign sif[s].fmt      = is_clk ? FMT_CMOS : FMT_OFF;
    assign sif[s].mute_en  = 1'b0;
    assign sif[s].mute_lvl = MUTE_LVL_RAIL;
    assign sif[s].sync     = sync_w;
    assign sif[s].run      = run_q;
    assign sif[s].src_ok   = 1'b1;
    assign sif[s].tick     = pll_tick_in;
    pscl_out_chan u_stat (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ch         (sif[s])
    );
    always_ff @(posedge clk_in) begin
      if (sys_rst_in || !run_q) begin
        stat_q[s] <= 1'b0;
        slew_q[s] <= 1'b0;
      end else begin
        stat_q[s] <= is_clk ? sif[s].pos : status_ind_in[s];
        slew_q[s] <= mode_r[STAT_SLEW_BIT];
      end
    end
  end

  // outputs from flops
  assign page_rd_en_out       = ld_en_q;
  assign page_rd_src_out      = src_q;
  assign page_rd_page_out     = page_q;
  assign page_rd_addr_out     = ld_addr_q;
  assign host_rd_data_out     = rd_data_q;
  assign host_rd_valid_out    = rd_valid_q;
  assign host_if_enable_out   = run_q;
  assign i2c_addr_lsb_out     = i2c_lsb_q;
  assign config_mode_hard_out = mode_hard_q;
  assign config_invalid_out   = invalid_q;
  assign config_page_id_out   = regs_q[REG_PAGE_ID];
  assign freq_offset_select_a_enable_out    = freq_offset_select_a_en_q;
  assign freq_offset_select_a_offset_out    = freq_offset_select_a_off_q;
  assign stat_pin_out         = stat_q;
  assign stat_slew_out        = slew_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_load_end_hard;
    st_q == ST_LOAD && load_done && mode_hard_q;
  endsequence

  sequence s_sync_then_run;
    (st_q == ST_SYNC) [*4] ##1 (st_q == ST_RUN);
  endsequence

  a_outputs_off_init: assert property (
    (!run_q) [*2] |-> (chan_oe_out == '0 && stat_pin_out == '0))
    else $error("outputs active before run");

  a_hard_addr_lsb: assert property (
    (run_q && mode_hard_q) |-> (i2c_addr_lsb_out == ADDR_LSB_HARD))
    else $error("hard mode address bits not zero");

  a_rom_page_latch: assert property (
    (st_q == ST_LATCH && cfg_hard_s) |=>
      (rom_page_q == $past(bin_s) && src_q == SRC_ROM))
    else $error("rom page not latched from straps");

  a_float_default: assert property (
    (st_q == ST_LATCH && !cfg_hard_s && lvl2_s == LVL_MID &&
     lvl3_s == LVL_MID) |=> (src_q == SRC_DEFAULT && !invalid_q))
    else $error("floating page pins did not pick defaults");

  a_bad_combo_flag: assert property (
    (st_q == ST_LATCH && !cfg_hard_s && combo_w >= COMBO_FIRST_BAD)
      |=> invalid_q)
    else $error("invalid page combination not flagged");

  a_soft_addr_vdd: assert property (
    (st_q == ST_LATCH && !cfg_hard_s && lvl1_s == LVL_VDD)
      |=> (i2c_lsb_q == ADDR_LSB_VDD))
    else $error("soft address bits wrong");

  a_hard_auto_sync: assert property (
    s_load_end_hard |=> s_sync_then_run)
    else $error("hard mode auto sync missing");

  a_straps_held: assert property (
    (run_q && $past(run_q)) |->
      ($stable(rom_page_q) && $stable(src_q) && $stable(i2c_lsb_q)))
    else $error("latched straps changed while running");

  a_host_write: assert property (
    (host_wr_en_in && host_ok && !cap_en_q) |=>
      (regs_q[$past(host_addr_in)] == $past(host_wr_data_in)))
    else $error("host write lost");

  a_freq_offset_select_a_follow: assert property (
    (run_q && !mode_hard_q) |=> (freq_offset_select_a_offset_out == $past(off_s)))
    else $error("freq_offset_select_a offset not following pin");

  a_soft_sync_hold: assert property (
    (run_q && !mode_hard_q && !sync_n_s) |=>
      (g_chan[0].u_chan.cnt_q == 8'h00 && !g_chan[0].u_chan.ph_q))
    else $error("active-low sync not applied");

  a_pdn_restart: assert property (
    (!pdn_n_s) |=> (st_q == ST_RESET && !host_if_enable_out))
    else $error("power-down pin did not restart");
endmodule // pscl_top
